/* design/scsp_map.vh */
// Purpose: constants for the system clock select and prescale block
// Assumes: one clock MCLK at 20 MHz, APB register access
// Notes: offsets are byte addresses of 32-bit words
`ifndef SCSP_MAP_VH
`define SCSP_MAP_VH
`define SCSP_OFF_CTRL 12'h000
`define SCSP_OFF_PRESC 12'h004
`define SCSP_OFF_TRIM0 12'h008
`define SCSP_OFF_TRIM1 12'h00C
`define SCSP_OFF_CFG 12'h010
`define SCSP_OFF_STAT 12'h014
`define SCSP_SRC_EXT 3'h0
`define SCSP_SRC_FAST 3'h1
`define SCSP_SRC_SLOW 3'h2
`define SCSP_SRC_WATCH 3'h3
`define SCSP_SRC_XTAL 3'h4
`define SCSP_SEL_EXT 4'h0
`define SCSP_SEL_FAST 4'h2
`define SCSP_SEL_SLOW 4'h4
`define SCSP_SEL_WATCH 4'h6
`define SCSP_DIV_ONE 4'h0
`define SCSP_DIV_EIGHT 4'h3
`define SCSP_DIV_MAX 4'h8
`define SCSP_ULP_MIN 3'h3
`define SCSP_ULP_32K 3'h7
`define SCSP_SUT_SHORT 16'd6
`define SCSP_SUT_RESET 16'd14
`define SCSP_SUT_258 16'd258
`define SCSP_SUT_1K 16'd1024
`define SCSP_SUT_16K 16'd16384
`define SCSP_SUT_32K 16'd32768
`define SCSP_RST_DELAY_MS 16
`define SCSP_SLOW_HZ 32768
`define SCSP_MCLK_HZ 20000000
`endif

/* design/scsp_top.v */
// Purpose: clock source select, start-up timing, trims and glitch-free prescaler
// Assumes: source clocks arrive as one-cycle enable pulses on MCLK
// Notes: the divided clock is an enable pulse; the output pin toggles on it
`timescale 1ns/10ps
`include "scsp_map.vh"
module scsp_top #(
  parameter SLOW_DIV = 610,
  parameter RST_TICKS = 524
) (
  // clock and reset
  input wire MCLK,
  input wire SYS_RST,
  // apb slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  // non-volatile configuration, 0 means programmed
  input wire [3:0] CFG_CLOCK_SOURCE_SELECT,
  input wire CFG_STARTUP_DELAY_SELECT,
  input wire [2:0] CFG_SLOW_OSC_FREQUENCY_SELECT,
  input wire CFG_CLOCK_OUTPUT_CONFIG,
  input wire CFG_DIVIDE_BY_EIGHT_CONFIG,
  input wire [7:0] FACTORY_FAST_TRIM,
  input wire [7:0] FACTORY_SLOW_TRIM,
  // source clock ticks and power-down wake
  input wire EXT_TICK,
  input wire FAST_TICK,
  input wire SLOW_TICK,
  input wire WATCH_TICK,
  input wire XTAL_TICK,
  input wire WAKE,
  // oscillator controls
  output reg [4:0] SRC_ENABLE,
  output reg [1:0] XTAL_RANGE,
  output reg [2:0] SLOW_FREQ,
  output reg [7:0] FAST_OSC_TRIM,
  output reg [7:0] SLOW_OSC_TRIM,
  // divided clock and status
  output reg SYS_TICK,
  output reg WDT_TICK,
  output reg RUN,
  output reg CLOCK_OUTPUT_PIN,
  output reg CLOCK_OUTPUT_OE
);
  localparam ST_RESET = 2'd0;
  localparam ST_RUN = 2'd1;
  localparam ST_WAKE = 2'd2;
  reg [1:0] state;
  reg [3:0] src_copy;
  reg sut_copy;
  reg [3:0] division_select;
  reg [3:0] div_active;
  reg [2:0] src_code;
  reg [15:0] start_count;
  reg [15:0] rst_count;
  reg [9:0] slow_div;
  reg [8:0] presc;
  reg presc_pend;
  reg [1:0] edge_cnt;
  reg src_tick;
  reg [15:0] wake_need;
  reg [8:0] next_presc;
  reg div_hit;
  wire apb_wr = PSEL && PENABLE && PWRITE;
  wire apb_rd = PSEL && PENABLE && !PWRITE;
  wire mapped = (PADDR == `SCSP_OFF_CTRL) || (PADDR == `SCSP_OFF_PRESC) ||
    (PADDR == `SCSP_OFF_TRIM0) || (PADDR == `SCSP_OFF_TRIM1) ||
    (PADDR == `SCSP_OFF_CFG) || (PADDR == `SCSP_OFF_STAT);
  // source decode with safe fallback to the fast oscillator
  always @* begin
    if (src_copy[3]) begin
      src_code = `SCSP_SRC_XTAL;
    end else begin
      case (src_copy)
        `SCSP_SEL_EXT: src_code = `SCSP_SRC_EXT;
        `SCSP_SEL_SLOW: src_code = `SCSP_SRC_SLOW;
        `SCSP_SEL_WATCH: src_code = `SCSP_SRC_WATCH;
        default: src_code = `SCSP_SRC_FAST;
      endcase
    end
  end
  always @* begin
    case (src_code)
      `SCSP_SRC_EXT: src_tick = EXT_TICK;
      `SCSP_SRC_SLOW: src_tick = SLOW_TICK;
      `SCSP_SRC_WATCH: src_tick = WATCH_TICK;
      `SCSP_SRC_XTAL: src_tick = XTAL_TICK;
      default: src_tick = FAST_TICK;
    endcase
  end
  // power-down start-up count per source
  always @* begin
    case (src_code)
      `SCSP_SRC_WATCH: wake_need = sut_copy ? `SCSP_SUT_32K : `SCSP_SUT_1K;
      `SCSP_SRC_XTAL: begin
        case ({src_copy[0], sut_copy})
          2'b00: wake_need = `SCSP_SUT_258;
          2'b01: wake_need = `SCSP_SUT_1K;
          default: wake_need = `SCSP_SUT_16K;
        endcase
      end
      default: wake_need = `SCSP_SUT_SHORT;
    endcase
  end
  // prescaler compare, count is never readable
  always @* begin
    next_presc = presc + 9'd1;
    div_hit = ((presc | ~((9'd1 << div_active) - 9'd1)) == 9'h1FF);
  end
  // apb registers
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      src_copy <= 4'h0;
      sut_copy <= 1'b0;
      division_select <= `SCSP_DIV_ONE;
      FAST_OSC_TRIM <= 8'h00;
      SLOW_OSC_TRIM <= 8'h00;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !mapped;
      if (state == ST_RESET) begin
        src_copy <= CFG_CLOCK_SOURCE_SELECT;
        sut_copy <= CFG_STARTUP_DELAY_SELECT;
        division_select <= CFG_DIVIDE_BY_EIGHT_CONFIG ? `SCSP_DIV_ONE :
          `SCSP_DIV_EIGHT;
        FAST_OSC_TRIM <= FACTORY_FAST_TRIM;
        SLOW_OSC_TRIM <= FACTORY_SLOW_TRIM;
      end else if (apb_wr && PREADY) begin
        case (PADDR)
          `SCSP_OFF_CTRL: begin
            src_copy <= PWDATA[3:0];
            sut_copy <= PWDATA[4];
          end
          `SCSP_OFF_PRESC: begin
            if (PWDATA[3:0] <= `SCSP_DIV_MAX) begin
              division_select <= PWDATA[3:0];
            end
          end
          `SCSP_OFF_TRIM0: FAST_OSC_TRIM <= PWDATA[7:0];
          `SCSP_OFF_TRIM1: SLOW_OSC_TRIM <= PWDATA[7:0];
          default: ;
        endcase
      end
      if (PSEL && !PENABLE && !PWRITE) begin
        case (PADDR)
          `SCSP_OFF_CTRL: PRDATA <= {27'h0, sut_copy, src_copy};
          `SCSP_OFF_PRESC: PRDATA <= {28'h0, division_select};
          `SCSP_OFF_TRIM0: PRDATA <= {24'h0, FAST_OSC_TRIM};
          `SCSP_OFF_TRIM1: PRDATA <= {24'h0, SLOW_OSC_TRIM};
          `SCSP_OFF_CFG: PRDATA <= {22'h0, CFG_DIVIDE_BY_EIGHT_CONFIG,
            CFG_CLOCK_OUTPUT_CONFIG, CFG_SLOW_OSC_FREQUENCY_SELECT,
            CFG_STARTUP_DELAY_SELECT, CFG_CLOCK_SOURCE_SELECT};
          `SCSP_OFF_STAT: PRDATA <= {26'h0, presc_pend, RUN, state, src_code[1:0]};
          default: PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end
  // 32kHz tick for watchdog and reset time-out
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      slow_div <= 10'h000;
      WDT_TICK <= 1'b0;
    end else begin
      WDT_TICK <= 1'b0;
      if (slow_div == SLOW_DIV[9:0] - 10'd1) begin
        slow_div <= 10'h000;
        WDT_TICK <= 1'b1;
      end else begin
        slow_div <= slow_div + 10'd1;
      end
    end
  end
  // start-up sequencer
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      state <= ST_RESET;
      start_count <= 16'h0000;
      rst_count <= 16'h0000;
      RUN <= 1'b0;
    end else begin
      case (state)
        ST_RESET: begin
          if (start_count < `SCSP_SUT_RESET) begin
            start_count <= start_count + {15'h0, src_tick};
          end else if (rst_count < RST_TICKS[15:0]) begin
            rst_count <= rst_count + {15'h0, WDT_TICK};
          end else begin
            state <= ST_RUN;
            RUN <= 1'b1;
          end
        end
        ST_RUN: begin
          if (WAKE) begin
            state <= ST_WAKE;
            RUN <= 1'b0;
            start_count <= 16'h0000;
          end
        end
        ST_WAKE: begin
          if (start_count < wake_need) begin
            start_count <= start_count + {15'h0, src_tick};
          end else begin
            state <= ST_RUN;
            RUN <= 1'b1;
          end
        end
        default: state <= ST_RESET;
      endcase
    end
  end
  // oscillator controls
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      SRC_ENABLE <= 5'h00;
      XTAL_RANGE <= 2'h0;
      SLOW_FREQ <= `SCSP_ULP_32K;
    end else begin
      SRC_ENABLE <= 5'h01 << src_code;
      XTAL_RANGE <= src_copy[2:1];
      SLOW_FREQ <= (CFG_SLOW_OSC_FREQUENCY_SELECT < `SCSP_ULP_MIN) ? `SCSP_ULP_32K :
        CFG_SLOW_OSC_FREQUENCY_SELECT;
    end
  end
  // prescaler: new division waits for an old-period boundary
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      presc <= 9'h000;
      div_active <= `SCSP_DIV_ONE;
      presc_pend <= 1'b0;
      edge_cnt <= 2'd0;
      SYS_TICK <= 1'b0;
    end else begin
      SYS_TICK <= 1'b0;
      if (division_select != div_active && !presc_pend) begin
        presc_pend <= 1'b1;
      end
      if (src_tick) begin
        if (div_hit) begin
          SYS_TICK <= 1'b1;
          presc <= 9'h000;
          if (presc_pend) begin
            div_active <= division_select;
            presc_pend <= 1'b0;
            edge_cnt <= 2'd2;
          end else if (edge_cnt != 2'd0) begin
            edge_cnt <= edge_cnt - 2'd1;
          end
        end else begin
          presc <= next_presc;
        end
      end
    end
  end
  // clock output pin
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      CLOCK_OUTPUT_PIN <= 1'b0;
      CLOCK_OUTPUT_OE <= 1'b0;
    end else begin
      CLOCK_OUTPUT_OE <= !CFG_CLOCK_OUTPUT_CONFIG && (state != ST_RESET);
      if (CLOCK_OUTPUT_OE && SYS_TICK) begin
        CLOCK_OUTPUT_PIN <= !CLOCK_OUTPUT_PIN;
      end
    end
  end
endmodule // scsp_top

/* dv/scsp_src.sv */
// Purpose: far-side model giving source clock ticks
// Assumes: every source runs at one fixed period of P cycles
// Notes: ticks are one-cycle pulses on MCLK
`timescale 1ns/10ps
module scsp_src #(
  parameter int P = 3
) (
  // clock
  input wire logic MCLK,
  // source ticks
  output logic [4:0] TICKS = 5'h0
);
  int n = 0;
  // period never steps between cycles
  always @(posedge MCLK) begin
    n <= (n == P - 1) ? 0 : n + 1;
    TICKS <= (n == P - 1) ? 5'h1F : 5'h00;
  end
endmodule // scsp_src

/* dv/scsp_chk.sv */
// Purpose: port checker for the clock select block
// Assumes: ready is registered from the setup cycle
// Notes: bound from tb_top
`timescale 1ns/10ps
module scsp_chk #(
  parameter SLOW_DIV = 610
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // clock outputs
  input wire logic [4:0] SRC_ENABLE,
  input wire logic [2:0] SLOW_FREQ,
  input wire logic SYS_TICK,
  input wire logic WDT_TICK,
  input wire logic RUN,
  input wire logic CLOCK_OUTPUT_PIN,
  input wire logic CLOCK_OUTPUT_OE
);
  int wcnt;
  logic wseen;
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // cycles since last watchdog tick
  always_ff @(posedge MCLK) begin
    if (SYS_RST || WDT_TICK) begin
      wcnt <= 0;
    end else begin
      wcnt <= wcnt + 1;
    end
    wseen <= !SYS_RST && (wseen || WDT_TICK);
  end
  AST_READY: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("ready not one cycle after setup");
  AST_PULSE: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  AST_ERR: assert property (PSLVERR |-> PREADY && (PWRITE || PRDATA == 32'h0))
    else $error("error response malformed");
  AST_ONEHOT: assert property ($onehot0(SRC_ENABLE))
    else $error("more than one source enabled");
  AST_ULP: assert property (SLOW_FREQ >= 3'h3)
    else $error("reserved slow frequency code");
  AST_RST: assert property (disable iff (1'b0) SYS_RST |=> !RUN && !CLOCK_OUTPUT_OE)
    else $error("clock output or run during reset");
  AST_PIN: assert property (CLOCK_OUTPUT_OE && $changed(CLOCK_OUTPUT_PIN)
    |-> SYS_TICK || $past(SYS_TICK))
    else $error("pin moved without divided tick");
  AST_WDT: assert property (WDT_TICK && wseen |-> wcnt == SLOW_DIV - 1)
    else $error("watchdog tick period wrong");
  C_RUN: cover property ($rose(RUN));
  C_ERR: cover property (PSLVERR);
  C_OUT: cover property (SYS_TICK && CLOCK_OUTPUT_OE);
endmodule // scsp_chk

/* dv/tb_top.sv */
// Purpose: self-checking bench for the clock select block
// Assumes: all sources tick every P cycles
// Notes: read data checked from a queue by a monitor
`timescale 1ns/10ps
module tb_top;
  localparam int P = 3;
  logic MCLK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, WAKE = 0;
  logic [11:0] PADDR = 12'h0;
  logic [31:0] PWDATA = 32'h0, t;
  logic [3:0] CFG_CLOCK_SOURCE_SELECT = 4'h2;
  logic CFG_STARTUP_DELAY_SELECT = 0, CFG_CLOCK_OUTPUT_CONFIG = 0, CFG_DIVIDE_BY_EIGHT_CONFIG = 0;
  logic [2:0] CFG_SLOW_OSC_FREQUENCY_SELECT = 3'h7;
  logic [7:0] FACTORY_FAST_TRIM = 8'h0, FACTORY_SLOW_TRIM = 8'h0;
  wire [31:0] PRDATA;
  wire [4:0] tk, SRC_ENABLE;
  wire [1:0] XTAL_RANGE;
  wire [2:0] SLOW_FREQ;
  wire [7:0] FAST_OSC_TRIM, SLOW_OSC_TRIM;
  wire PREADY, PSLVERR, SYS_TICK, WDT_TICK, RUN, CLOCK_OUTPUT_PIN, CLOCK_OUTPUT_OE;
  int bad_count = 0, samples_checked = 0, c, g;
  logic [31:0] q[$];
  logic [3:0] sel[7] = '{4'h0, 4'h1, 4'h4, 4'h6, 4'h8, 4'hE, 4'h2};
  logic [4:0] oh[7] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h10, 5'h02};
  scsp_src #(.P(P)) src (.MCLK, .TICKS(tk));
  scsp_top #(.SLOW_DIV(4), .RST_TICKS(2)) uut (.MCLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE,
    .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .CFG_CLOCK_SOURCE_SELECT,
    .CFG_STARTUP_DELAY_SELECT, .CFG_SLOW_OSC_FREQUENCY_SELECT, .CFG_CLOCK_OUTPUT_CONFIG,
    .CFG_DIVIDE_BY_EIGHT_CONFIG, .FACTORY_FAST_TRIM, .FACTORY_SLOW_TRIM, .EXT_TICK(tk[0]),
    .FAST_TICK(tk[1]), .SLOW_TICK(tk[2]), .WATCH_TICK(tk[3]), .XTAL_TICK(tk[4]), .WAKE,
    .SRC_ENABLE, .XTAL_RANGE, .SLOW_FREQ, .FAST_OSC_TRIM, .SLOW_OSC_TRIM, .SYS_TICK,
    .WDT_TICK, .RUN, .CLOCK_OUTPUT_PIN, .CLOCK_OUTPUT_OE);
  initial forever #25 MCLK = ~MCLK;
  task automatic check(string n, logic [31:0] s, logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [31:0] e, logic er);
    int n;
    @(posedge MCLK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    if (!w) q.push_back(e);
    @(posedge MCLK);
    PENABLE <= 1;
    n = 0;
    do @(posedge MCLK); while (PREADY !== 1'b1 && ++n < 50);
    check("pslverr", PSLVERR, er);
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  always @(posedge MCLK) begin
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE && q.size() > 0) begin
      check("prdata", PRDATA, q.pop_front());
    end
  end
  task automatic waitrun();
    c = 0;
    while (RUN !== 1'b1 && c < 5000) begin
      @(posedge MCLK);
      c++;
    end
  endtask
  task automatic gap();
    c = 0;
    while (SYS_TICK !== 1'b1 && c < 3000) begin
      @(posedge MCLK);
      c++;
    end
    g = 0;
    do begin
      @(posedge MCLK);
      g++;
    end while (SYS_TICK !== 1'b1 && g < 3000);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #(50 * 40000);
    bad_count++;
    results();
  end
  initial begin
    void'($urandom(84969));
    FACTORY_FAST_TRIM <= $urandom;
    FACTORY_SLOW_TRIM <= $urandom;
    repeat (4) @(posedge MCLK);
    SYS_RST <= 0;
    waitrun();
    check("run_delay", c >= 13 * P + 4 && c < 5000, 1);
    check("src_en", SRC_ENABLE, 5'h02);
    check("fast_trim", FAST_OSC_TRIM, FACTORY_FAST_TRIM);
    check("slow_trim", SLOW_OSC_TRIM, FACTORY_SLOW_TRIM);
    $display("test reset done");
    apb(0, 12'h004, 0, 32'h0000_0003, 0);
    apb(0, 12'h010, 0, 32'h0000_00E2, 0);
    apb(1, 12'h010, 32'h0000_03FF, 0, 0);
    apb(0, 12'h010, 0, 32'h0000_00E2, 0);
    apb(0, 12'h100, 0, 32'h0000_0000, 1);
    t = $urandom & 32'h0000_00FF;
    apb(1, 12'h008, t, 0, 0);
    apb(0, 12'h008, 0, t, 0);
    check("fast_trim_out", FAST_OSC_TRIM, t);
    $display("test registers done");
    foreach (sel[i]) begin
      apb(1, 12'h000, {28'h0, sel[i]}, 0, 0);
      c = 0;
      while (SRC_ENABLE !== oh[i] && c < 500) begin
        @(posedge MCLK);
        c++;
      end
      repeat (2) @(posedge MCLK);
      check("src_switch", SRC_ENABLE, oh[i]);
      if (sel[i][3]) check("xtal_range", XTAL_RANGE, sel[i][2:1]);
    end
    $display("test sources done");
    for (int d = 0; d < 10; d++) begin
      apb(1, 12'h004, d, 0, 0);
      apb(0, 12'h004, 0, d > 8 ? 8 : d, 0);
      gap();
      gap();
      check("tick_gap", g, P << (d > 8 ? 8 : d));
    end
    check("out_en", CLOCK_OUTPUT_OE, 1);
    $display("test prescaler done");
    WAKE <= 1;
    @(posedge MCLK);
    WAKE <= 0;
    repeat (2) @(posedge MCLK);
    check("run_wake", RUN, 0);
    waitrun();
    check("wake_delay", c >= 5 * P - 3 && c < 5000, 1);
    $display("test wake done");
    SYS_RST <= 1;
    repeat (2) @(posedge MCLK);
    check("rst_out", {RUN, CLOCK_OUTPUT_OE}, 0);
    SYS_RST <= 0;
    waitrun();
    check("rerun", RUN, 1);
    $display("test second reset done");
    results();
  end
endmodule // tb_top
bind scsp_top scsp_chk #(.SLOW_DIV(SLOW_DIV)) chk (.MCLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE,
  .PRDATA, .PREADY, .PSLVERR, .SRC_ENABLE, .SLOW_FREQ, .SYS_TICK, .WDT_TICK, .RUN,
  .CLOCK_OUTPUT_PIN, .CLOCK_OUTPUT_OE);
